// ===== pmwk_pkg.sv
// shared constants, carriers and decoders for the wakeup/charger/key register slice
package pmwk_pkg;

  localparam logic [7:0] OFS_WAKE = 8'h31;
  localparam logic [7:0] OFS_LED = 8'h32;
  localparam logic [7:0] OFS_CHG1 = 8'h33;
  localparam logic [7:0] OFS_CHG2 = 8'h34;
  localparam logic [7:0] OFS_CHG3 = 8'h35;
  localparam logic [7:0] OFS_KEY = 8'h36;

  localparam logic [7:0] RST_WAKE = 8'h03;
  localparam logic [7:0] RST_LED = 8'h43;
  localparam logic [7:0] RST_CHG1 = 8'hc5;
  localparam logic [7:0] RST_CHG2 = 8'h45;
  localparam logic [7:0] RST_CHG3 = 8'h18;
  localparam logic [7:0] RST_KEY = 8'h59;

  // writable bits; reserved bits are never stored and read as zero
  localparam logic [7:0] MSK_WAKE = 8'hbf;
  localparam logic [7:0] MSK_LED = 8'h7f;
  localparam logic [7:0] MSK_CHG1 = 8'hff;
  localparam logic [7:0] MSK_CHG2 = 8'hf7;
  localparam logic [7:0] MSK_CHG3 = 8'hf8;
  localparam logic [7:0] MSK_KEY = 8'hff;

  localparam int B_PG_HOLD = 7;
  localparam int B_SWWAKE = 5;
  localparam int B_WAKE_IRQ = 4;
  localparam int B_WAKE_EN = 3;
  localparam int B_BAT_DET = 6;
  localparam int B_LED_SRC = 3;
  localparam int B_CHG_EN = 7;
  localparam int B_CHG_END = 4;
  localparam int B_KEEP_ON = 5;
  localparam int B_LED_TYPE = 4;
  localparam int B_TEMP_LOOP = 3;
  localparam int B_KEY_OFF_EN = 3;
  localparam int B_AUTO_ON = 2;

  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned TICK_PERIOD_NS = 1000000;
  localparam int unsigned TICK_DEF_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  localparam logic [6:0] WAKE_PERIOD_MS = 7'h40;
  localparam logic [6:0] PG_DELAY_BASE_MS = 7'h08;
  localparam logic [10:0] LED_SLOW_PERIOD_MS = 11'h7d0;
  localparam logic [10:0] LED_SLOW_LOW_MS = 11'h1f4;
  localparam logic [10:0] LED_FAST_PERIOD_MS = 11'h1f4;
  localparam logic [10:0] LED_FAST_LOW_MS = 11'h07d;
  localparam logic [13:0] KEY_MAX_MS = 14'h3fff;
  localparam logic [13:0] KEY_ON_SHORT_MS = 14'h0080;
  localparam logic [13:0] KEY_ON_STEP_MS = 14'h03e8;
  localparam logic [13:0] KEY_IRQ_BASE_MS = 14'h03e8;
  localparam logic [13:0] KEY_IRQ_STEP_MS = 14'h01f4;
  localparam logic [13:0] KEY_OFF_BASE_MS = 14'h0fa0;
  localparam logic [13:0] KEY_OFF_STEP_MS = 14'h07d0;
  localparam logic [11:0] SHDN_BASE_MV = 12'h0a28;
  localparam logic [11:0] SHDN_STEP_MV = 12'h064;
  localparam logic [11:0] CHG_CUR_STEP_MA = 12'h0c8;
  localparam logic [3:0] CHG_CUR_TOP_CODE = 4'hd;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pmwk_bus_s;

  typedef struct packed {
    logic chg_enable;
    logic chg_out_on;
    logic chg_done;
    logic end_20pct;
    logic bat_detect_en;
    logic temp_loop_en;
    logic led_type_b;
    logic [1:0] pre_timer;
    logic [1:0] fast_timer;
    logic [2:0] shutdown_voltage_threshold;
    logic [11:0] shutdown_mv;
    logic [12:0] vtarget_mv;
    logic [11:0] programmed_charge_current;
    logic [11:0] ilim_ma;
  } pmwk_cfg_s;

  typedef struct packed {
    logic [7:0] r31, r32, r33, r34, r35, r36;
    logic [7:0] rdata;
    logic vbus_d;
    logic [6:0] wake_ms;
    logic [6:0] pg_ms;
    logic pg_ok;
    logic [10:0] led_ms;
    logic [13:0] key_ms;
    logic restart_pend;
    logic irq_pin;
    logic rails_wake;
    logic pg_out;
    logic led_o;
    logic led_oe;
    logic key_on;
    logic key_irq;
    logic key_off;
    logic key_restart;
    pmwk_cfg_s cfg;
  } pmwk_state_s;

  typedef struct packed {
    logic [16:0] cnt;
    logic tick;
  } pmwk_tick_s;

  function automatic logic [12:0] pmwk_vtarget_mv(input logic [1:0] c);
    case (c)
      2'b00: return 13'h1004;
      2'b01: return 13'h1036;
      2'b10: return 13'h1068;
      default: return 13'h10fe;
    endcase
  endfunction

  function automatic logic [11:0] pmwk_ilim_ma(input logic [3:0] c);
    case (c)
      4'h0: return 12'h064;
      4'h1: return 12'h1f4;
      4'h2: return 12'h384;
      4'h3: return 12'h5dc;
      4'h4: return 12'h7d0;
      4'h5: return 12'h9c4;
      4'h6: return 12'hbb8;
      4'h7: return 12'hdac;
      default: return 12'hfa0;
    endcase
  endfunction

endpackage

// ===== pmwk_tick.sv
// one millisecond timebase enable for the register slice
`timescale 1ns/10ps
module pmwk_tick
  import pmwk_pkg::*;
#(
  parameter int unsigned CYCLES = TICK_DEF_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  output logic tick
);

  pmwk_tick_s st;
  pmwk_tick_s next_st;

  always_comb begin
    next_st.tick = (st.cnt == 17'(CYCLES - 1));
    next_st.cnt = next_st.tick ? 17'h0_0000 : 17'(st.cnt + 17'h0_0001);
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

endmodule

// ===== pmwk_regs.sv
// wakeup, indicator, charger and power key register slice
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
module pmwk_regs
  import pmwk_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_DEF_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic sys_reset,
  input wire pmwk_bus_s bus,
  output logic [7:0] rdata,
  input wire logic vbus_present,
  input wire logic irq_in,
  input wire logic rails_good,
  input wire logic power_key_input_n,
  input wire logic [1:0] chg_led_code_a,
  input wire logic [1:0] chg_led_code_b,
  input wire logic charging,
  input wire logic [11:0] actual_charge_current,
  output logic irq_pin,
  output logic rails_wake,
  output logic power_good_output,
  output logic charge_indicator_pin_o,
  output logic charge_indicator_pin_oe,
  output logic key_on_event,
  output logic key_irq,
  output logic key_shutdown,
  output logic key_restart,
  output pmwk_cfg_s cfg
);

  pmwk_state_s st;
  pmwk_state_s next_st;
  logic tick;
  logic wake_go;
  logic [1:0] led_code;
  logic [10:0] led_period;
  logic [10:0] led_low;
  logic [6:0] pg_delay;
  logic [13:0] key_next;
  logic [13:0] on_ms;
  logic [13:0] irq_ms;
  logic [13:0] off_ms;
  logic [3:0] cur_code;
  logic [15:0] act_scaled;

  pmwk_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .tick(tick)
  );

  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;
    next_st.vbus_d = vbus_present;
    next_st.key_on = 1'b0;
    next_st.key_irq = 1'b0;
    next_st.key_off = 1'b0;
    next_st.key_restart = 1'b0;
    next_st.led_o = 1'b0;

    next_st.r31[B_SWWAKE] = 1'b0;

    if (bus.wr) begin
      case (bus.addr)
        OFS_WAKE: next_st.r31 = bus.wdata & MSK_WAKE;
        OFS_LED: next_st.r32 = bus.wdata & MSK_LED;
        OFS_CHG1: next_st.r33 = bus.wdata & MSK_CHG1;
        OFS_CHG2: next_st.r34 = bus.wdata & MSK_CHG2;
        OFS_CHG3: next_st.r35 = bus.wdata & MSK_CHG3;
        OFS_KEY: next_st.r36 = bus.wdata & MSK_KEY;
        default: ;
      endcase
    end
    if (bus.rd) begin
      case (bus.addr)
        OFS_WAKE: next_st.rdata = st.r31;
        OFS_LED: next_st.rdata = st.r32;
        OFS_CHG1: next_st.rdata = st.r33;
        OFS_CHG2: next_st.rdata = st.r34;
        OFS_CHG3: next_st.rdata = st.r35;
        OFS_KEY: next_st.rdata = st.r36;
        default: next_st.rdata = 8'h00;
      endcase
    end

    if (sys_reset) begin
      next_st.r31[B_WAKE_EN] = RST_WAKE[B_WAKE_EN];
      next_st.r33[B_CHG_EN] = RST_CHG1[B_CHG_EN];
      next_st.r36[B_KEY_OFF_EN] = RST_KEY[B_KEY_OFF_EN];
    end
    // falling VBUS restores the bus current limit
    if (st.vbus_d && !vbus_present) begin
      next_st.r35[7:4] = RST_CHG3[7:4];
    end

    // wake by software bit or unmasked interrupt
    wake_go = st.r31[B_WAKE_EN] &&
              (st.r31[B_SWWAKE] || (irq_in && !st.r31[B_WAKE_IRQ]));
    if (wake_go) begin
      next_st.wake_ms = WAKE_PERIOD_MS;
    end else if (tick && st.wake_ms != 7'h00) begin
      next_st.wake_ms = st.wake_ms - 7'h01;
    end
    next_st.rails_wake = (next_st.wake_ms != 7'h00);
    // pin masked while interrupts are routed to wakeup
    next_st.irq_pin = irq_in && !(st.r31[B_WAKE_EN] && !st.r31[B_WAKE_IRQ]);

    pg_delay = PG_DELAY_BASE_MS << st.r32[1:0];
    if (!rails_good) begin
      next_st.pg_ms = 7'h00;
      next_st.pg_ok = 1'b0;
    end else if (tick && !st.pg_ok) begin
      next_st.pg_ms = st.pg_ms + 7'h01;
      next_st.pg_ok = (next_st.pg_ms >= pg_delay);
    end
    // hold power-good low during the wake period
    next_st.pg_out = next_st.pg_ok &&
                     !(next_st.rails_wake && next_st.r31[B_PG_HOLD]);

    if (st.r32[B_LED_SRC]) begin
      led_code = st.r34[B_LED_TYPE] ? chg_led_code_b : chg_led_code_a;
    end else begin
      led_code = st.r32[5:4];
    end
    // blink at 25 percent low time
    led_period = (led_code == 2'b01) ? LED_SLOW_PERIOD_MS : LED_FAST_PERIOD_MS;
    led_low = (led_code == 2'b01) ? LED_SLOW_LOW_MS : LED_FAST_LOW_MS;
    if (tick) begin
      if (st.led_ms >= led_period - 11'h001) begin
        next_st.led_ms = 11'h000;
      end else begin
        next_st.led_ms = st.led_ms + 11'h001;
      end
    end
    case (led_code)
      2'b00: next_st.led_oe = 1'b0;
      2'b11: next_st.led_oe = 1'b1;
      default: next_st.led_oe = (next_st.led_ms < led_low);
    endcase

    on_ms = (st.r36[7:6] == 2'b00) ? KEY_ON_SHORT_MS :
            14'(KEY_ON_STEP_MS * 14'(st.r36[7:6]));
    irq_ms = 14'(KEY_IRQ_BASE_MS + KEY_IRQ_STEP_MS * 14'(st.r36[5:4]));
    off_ms = 14'(KEY_OFF_BASE_MS + KEY_OFF_STEP_MS * 14'(st.r36[1:0]));
    key_next = st.key_ms + 14'h0001;
    if (power_key_input_n) begin
      next_st.key_ms = 14'h0000;
      // restart once the key is let go
      if (st.restart_pend) begin
        next_st.key_restart = 1'b1;
        next_st.restart_pend = 1'b0;
      end
    end else if (tick && st.key_ms != KEY_MAX_MS) begin
      next_st.key_ms = key_next;
      next_st.key_on = (key_next == on_ms);
      // key interrupt at the hold time
      next_st.key_irq = (key_next == irq_ms);
      // shutdown when held to the off time
      if (st.r36[B_KEY_OFF_EN] && key_next == off_ms) begin
        next_st.key_off = 1'b1;
        next_st.restart_pend = st.r36[B_AUTO_ON];
      end
    end

    next_st.cfg.shutdown_voltage_threshold = st.r31[2:0];
    next_st.cfg.shutdown_mv = 12'(SHDN_BASE_MV + SHDN_STEP_MV * 12'(st.r31[2:0]));
    next_st.cfg.vtarget_mv = pmwk_vtarget_mv(st.r33[6:5]);
    cur_code = (st.r33[3:0] > CHG_CUR_TOP_CODE) ? CHG_CUR_TOP_CODE : st.r33[3:0];
    next_st.cfg.programmed_charge_current =
      12'(CHG_CUR_STEP_MA * (12'(cur_code) + 12'h001));
    next_st.cfg.ilim_ma = pmwk_ilim_ma(st.r35[7:4]);
    next_st.cfg.bat_detect_en = st.r32[B_BAT_DET];
    next_st.cfg.pre_timer = st.r34[7:6];
    next_st.cfg.fast_timer = st.r34[1:0];
    next_st.cfg.temp_loop_en = st.r35[B_TEMP_LOOP];
    next_st.cfg.led_type_b = st.r34[B_LED_TYPE];
    next_st.cfg.end_20pct = st.r33[B_CHG_END];
    next_st.cfg.chg_enable = st.r33[B_CHG_EN];

    // end of charge below 10 or 20 percent
    act_scaled = st.r33[B_CHG_END] ? 16'(actual_charge_current * 16'h0005) :
                 16'(actual_charge_current * 16'h000a);
    if (!st.r33[B_CHG_EN] || !charging) begin
      next_st.cfg.chg_done = 1'b0;
    end else if (act_scaled < 16'(st.cfg.programmed_charge_current)) begin
      next_st.cfg.chg_done = 1'b1;
    end
    // charger output after end of charge
    next_st.cfg.chg_out_on = next_st.cfg.chg_enable &&
                             !(next_st.cfg.chg_done && !st.r34[B_KEEP_ON]);
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.r31 <= RST_WAKE;
      st.r32 <= RST_LED;
      st.r33 <= RST_CHG1;
      st.r34 <= RST_CHG2;
      st.r35 <= RST_CHG3;
      st.r36 <= RST_KEY;
      st.vbus_d <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign irq_pin = st.irq_pin;
  assign rails_wake = st.rails_wake;
  assign power_good_output = st.pg_out;
  assign charge_indicator_pin_o = st.led_o;
  assign charge_indicator_pin_oe = st.led_oe;
  assign key_on_event = st.key_on;
  assign key_irq = st.key_irq;
  assign key_shutdown = st.key_off;
  assign key_restart = st.key_restart;
  assign cfg = st.cfg;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  a_pg_hold_low: assert property (
    st.rails_wake && st.r31[B_PG_HOLD] |-> !st.pg_out)
    else $error("power good high during held wake");
  a_swwake_self_clear: assert property (
    st.r31[B_SWWAKE] && !(bus.wr && bus.addr == OFS_WAKE) |=> !st.r31[B_SWWAKE])
    else $error("software wake bit did not clear");
  a_swwake_starts_wake: assert property (
    st.r31[B_SWWAKE] && st.r31[B_WAKE_EN] |=> st.rails_wake && st.wake_ms == WAKE_PERIOD_MS)
    else $error("software wake did not wake rails");
  a_irq_pin_mask: assert property (
    st.r31[B_WAKE_EN] && !st.r31[B_WAKE_IRQ] |=> !st.irq_pin)
    else $error("interrupt pin not masked");
  a_led_drive_low: assert property (
    !st.r32[B_LED_SRC] && st.r32[5:4] == 2'b11 |=> st.led_oe)
    else $error("indicator not driven low");
  a_reserved_zero: assert property (
    bus.rd && bus.addr == OFS_WAKE |=> st.rdata[6] == 1'b0)
    else $error("reserved bit read as one");
  a_vbus_fall_ilim: assert property (
    st.vbus_d && !vbus_present |=> st.r35[7:4] == RST_CHG3[7:4])
    else $error("bus limit not restored on vbus fall");
  a_sysrst_bits: assert property (
    sys_reset |=> !st.r31[B_WAKE_EN] && st.r33[B_CHG_EN] && st.r36[B_KEY_OFF_EN])
    else $error("system reset bits not restored");
  a_key_release: assert property (
    power_key_input_n |=> st.key_ms == 14'h0000)
    else $error("key counter kept running after release");
  a_chg_drop_out: assert property (
    st.cfg.chg_done && !st.r34[B_KEEP_ON] ##1 st.cfg.chg_done |-> !st.cfg.chg_out_on)
    else $error("charger output on after done");
  a_pg_drop_fast: assert property (
    !rails_good |=> !st.pg_ok && !st.pg_out)
    else $error("power good stayed high without good rails");
  a_pg_delay_min: assert property (
    $rose(st.pg_ok) |-> st.pg_ms >= (PG_DELAY_BASE_MS << $past(st.r32[1:0])))
    else $error("power good raised before its delay");
  a_wake_irq_start: assert property (
    st.r31[B_WAKE_EN] && !st.r31[B_WAKE_IRQ] && irq_in |=> st.wake_ms == WAKE_PERIOD_MS)
    else $error("unmasked interrupt did not start wake");
  a_wake_irq_block: assert property (
    st.r31[B_WAKE_IRQ] && !st.r31[B_SWWAKE] && st.wake_ms == 7'h00 |=> !st.rails_wake)
    else $error("interrupt woke rails while routed to pin");
  a_wake_disabled: assert property (
    !st.r31[B_WAKE_EN] && st.wake_ms == 7'h00 |=> !st.rails_wake)
    else $error("rails woke with wake function disabled");
  a_led_hiz: assert property (
    !st.r32[B_LED_SRC] && st.r32[5:4] == 2'b00 |=> !st.led_oe)
    else $error("indicator driven in high impedance mode");
  a_led_type_a: assert property (
    st.r32[B_LED_SRC] && !st.r34[B_LED_TYPE] && chg_led_code_a == 2'b11 |=> st.led_oe)
    else $error("indicator ignores charger type A code");
  a_led_type_b: assert property (
    st.r32[B_LED_SRC] && st.r34[B_LED_TYPE] && chg_led_code_b == 2'b00 |=> !st.led_oe)
    else $error("indicator ignores charger type B code");
  a_key_irq_time: assert property (
    st.key_irq |->
      st.key_ms == 14'(KEY_IRQ_BASE_MS + KEY_IRQ_STEP_MS * 14'($past(st.r36[5:4]))))
    else $error("key interrupt at wrong hold time");
  a_key_off_gated: assert property (
    st.key_off |-> $past(st.r36[B_KEY_OFF_EN]) &&
      st.key_ms == 14'(KEY_OFF_BASE_MS + KEY_OFF_STEP_MS * 14'($past(st.r36[1:0]))))
    else $error("key shutdown not gated or at wrong time");
  a_restart_gated: assert property (
    st.key_off |-> st.restart_pend == $past(st.r36[B_AUTO_ON]))
    else $error("automatic restart armed against its setting");
  a_cur_clamp: assert property (
    st.r33[3:0] > CHG_CUR_TOP_CODE |=> st.cfg.programmed_charge_current == 12'haf0)
    else $error("reserved current code not clamped");
  a_ilim_top: assert property (
    st.r35[7] |=> st.cfg.ilim_ma == 12'hfa0)
    else $error("bus limit top codes not at maximum");
  a_shdn_top: assert property (
    st.r31[2:0] == 3'h7 |=> st.cfg.shutdown_mv == 12'hce4)
    else $error("shutdown voltage top code wrong");
  a_vtarget_top: assert property (
    st.r33[6:5] == 2'b11 |=> st.cfg.vtarget_mv == 13'h10fe)
    else $error("charge target top code wrong");
  a_chg_done_clear: assert property (
    !charging |=> !st.cfg.chg_done)
    else $error("charge done kept while not charging");

  c_sw_wake: cover property (st.r31[B_SWWAKE] ##1 st.rails_wake);
  c_key_off: cover property (st.key_off ##[1:300] st.key_restart);
  c_led_blink: cover property ($fell(st.led_oe) && !st.r32[B_LED_SRC]);
  c_irq_wake: cover property (irq_in && st.r31[B_WAKE_EN] && !st.r31[B_WAKE_IRQ] ##1 st.rails_wake);
  c_chg_done: cover property ($rose(st.cfg.chg_done) && !st.r34[B_KEEP_ON]);

endmodule

// ===== pmwk_far_model.sv
// power key and indicator lamp standing at the far side of the slice
`timescale 1ns/10ps
module pmwk_far_model (
  input wire logic press,
  input wire logic led_o,
  input wire logic led_oe,
  output logic key_n,
  output logic led_level
);
  // key line has a pull-up, pressed shorts it low
  assign key_n = press ? 1'b0 : 1'b1;
  // lamp pin pulled up when not driven
  assign led_level = led_oe ? led_o : 1'b1;
endmodule

// ===== tb_top.sv
// self-checking bench for the wakeup, charger and key register slice
`timescale 1ns/10ps
module tb_top;
  import pmwk_pkg::*;
  localparam int TCK = 2;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic sys_reset = 1'b0;
  pmwk_bus_s bus = '0;
  logic vbus_present = 1'b1;
  logic irq_in = 1'b0;
  logic rails_good = 1'b0;
  logic press = 1'b0;
  logic [1:0] code_a = 2'b11;
  logic [1:0] code_b = 2'b00;
  logic charging = 1'b0;
  logic [11:0] cur_ma = 12'h000;
  logic [7:0] rdata;
  logic key_n, led_level, irq_pin, rails_wake, pg_out, led_o, led_oe;
  logic key_on, key_irq, key_off, key_rst;
  pmwk_cfg_s cfg;
  int mismatches = 0;
  int checks = 0;
  int seed = 69681;
  logic [7:0] ofs[6] = '{OFS_WAKE, OFS_LED, OFS_CHG1, OFS_CHG2, OFS_CHG3, OFS_KEY};
  logic [7:0] rstv[6] = '{RST_WAKE, RST_LED, RST_CHG1, RST_CHG2, RST_CHG3, RST_KEY};
  logic [7:0] msk[6] = '{MSK_WAKE, MSK_LED, MSK_CHG1, MSK_CHG2, MSK_CHG3, MSK_KEY};
  int ilim_t[8] = '{100, 500, 900, 1500, 2000, 2500, 3000, 3500};
  int vt_t[4] = '{4100, 4150, 4200, 4350};
  int per[4] = '{4, 2000 * TCK, 500 * TCK, 4};
  int lo[4] = '{0, 500 * TCK, 125 * TCK, 4};
  logic [7:0] c33[5] = '{8'h85, 8'h85, 8'h95, 8'h95, 8'h85};
  logic [7:0] c34[5] = '{8'h45, 8'h45, 8'h45, 8'h45, 8'h65};
  int cur[5] = '{100, 130, 230, 240, 100};
  logic dn[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

  pmwk_regs #(.TICK_CYCLES(TCK)) pmwk_regs_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .sys_reset(sys_reset), .bus(bus), .rdata(rdata), .vbus_present(vbus_present),
    .irq_in(irq_in), .rails_good(rails_good), .power_key_input_n(key_n),
    .chg_led_code_a(code_a), .chg_led_code_b(code_b), .charging(charging),
    .actual_charge_current(cur_ma), .irq_pin(irq_pin), .rails_wake(rails_wake),
    .power_good_output(pg_out), .charge_indicator_pin_o(led_o),
    .charge_indicator_pin_oe(led_oe), .key_on_event(key_on), .key_irq(key_irq),
    .key_shutdown(key_off), .key_restart(key_rst), .cfg(cfg));
  pmwk_far_model pmwk_far_model_inst (.press(press), .led_o(led_o), .led_oe(led_oe),
    .key_n(key_n), .led_level(led_level));

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  function automatic logic near(input int t, input int e);
    return (t >= e - 6) && (t <= e + 6);
  endfunction

  // decoded settings must follow the byte just written
  task automatic chk_cfg(input int k, input logic [7:0] d);
    case (k)
      0: begin
        chk(32'(cfg.shutdown_voltage_threshold), 32'(d[2:0]));
        chk(32'(cfg.shutdown_mv), 2600 + 100 * d[2:0]);
      end
      1: chk(32'(cfg.bat_detect_en), 32'(d[6]));
      2: begin
        chk(32'(cfg.chg_enable), 32'(d[7]));
        chk(32'(cfg.vtarget_mv), vt_t[d[6:5]]);
        chk(32'(cfg.end_20pct), 32'(d[4]));
        chk(32'(cfg.programmed_charge_current), (d[3:0] < 4'he) ? 200 * (d[3:0] + 1) : 2800);
        chk(32'(cfg.chg_out_on), 32'(d[7]));
      end
      3: begin
        chk(32'(cfg.pre_timer), 32'(d[7:6]));
        chk(32'(cfg.led_type_b), 32'(d[4]));
        chk(32'(cfg.fast_timer), 32'(d[1:0]));
      end
      4: begin
        chk(32'(cfg.temp_loop_en), 32'(d[3]));
        chk(32'(cfg.ilim_ma), d[7] ? 4000 : ilim_t[d[6:4]]);
      end
      default: ;
    endcase
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk);
    mismatches++;
    $display("[FAIL] t=%0t seen=%h exp=%h", $time, 32'h0, 32'h1);
    end_sim();
  end

  initial begin
    int i, c, n, k, t_on, t_irq, t_off;
    logic [7:0] d, v;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    cyc(2);
    for (k = 0; k < 6; k++) begin
      rd(ofs[k], v);
      chk(v, rstv[k]);
      chk_cfg(k, rstv[k]);
    end
    rd(8'h30, v);
    chk(v, 8'h00);
    wr(8'h37, 8'hff);
    rd(8'h37, v);
    chk(v, 8'h00);
    $display("test reset_and_map done");
    for (c = 0; c < 16; c++) begin
      wr(OFS_CHG3, {c[3:0], 4'h8});
      wr(OFS_WAKE, {5'h00, c[2:0]});
      wr(OFS_CHG1, {1'b1, c[1:0], 1'b0, c[3:0]});
      cyc(2);
      chk_cfg(4, {c[3:0], 4'h8});
      chk_cfg(0, {5'h00, c[2:0]});
      chk_cfg(2, {1'b1, c[1:0], 1'b0, c[3:0]});
    end
    for (i = 0; i < 40; i++) begin
      k = ($random(seed) & 32'h7fff_ffff) % 6;
      d = 8'($random(seed));
      if (k == 0) d[5] = 1'b0;
      wr(ofs[k], d);
      rd(ofs[k], v);
      chk(v, d & msk[k]);
      cyc(2);
      chk_cfg(k, d);
    end
    $display("test codes_and_random done");
    // system reset restores its own bits only
    wr(OFS_WAKE, 8'h0b);
    wr(OFS_CHG1, 8'h05);
    wr(OFS_KEY, 8'h51);
    @(posedge sys_clk);
    sys_reset <= 1'b1;
    @(posedge sys_clk);
    sys_reset <= 1'b0;
    rd(OFS_WAKE, v);
    chk(v, 8'h03);
    rd(OFS_CHG1, v);
    chk(v, 8'h85);
    rd(OFS_KEY, v);
    chk(v, 8'h59);
    wr(OFS_CHG3, 8'h70);
    @(posedge sys_clk);
    vbus_present <= 1'b0;
    cyc(3);
    rd(OFS_CHG3, v);
    chk(v, 8'h10);
    vbus_present <= 1'b1;
    $display("test reset_domains done");
    for (c = 0; c < 4; c++) begin
      @(posedge sys_clk);
      rails_good <= 1'b0;
      wr(OFS_LED, 8'h40 | 8'(c));
      cyc(3);
      rails_good <= 1'b1;
      for (n = 0; n < 200 * TCK && !pg_out; n++) cyc(1);
      chk(32'(near(n, (8 << c) * TCK)), 32'h1);
    end
    $display("test power_good_delay done");
    wr(OFS_WAKE, 8'h88);
    wr(OFS_WAKE, 8'ha8);
    for (n = 0; n < 6 && !rails_wake; n++) cyc(1);
    chk(32'(rails_wake), 32'h1);
    chk(32'(pg_out), 32'h0);
    for (n = 0; n < 200 * TCK && rails_wake; n++) cyc(1);
    chk(32'(near(n, 64 * TCK)), 32'h1);
    cyc(2);
    chk(32'(pg_out), 32'h1);
    rd(OFS_WAKE, v);
    chk(v, 8'h88);
    wr(OFS_WAKE, 8'h08);
    irq_in <= 1'b1;
    cyc(3);
    chk(32'(rails_wake), 32'h1);
    chk(32'(irq_pin), 32'h0);
    chk(32'(pg_out), 32'h1);
    irq_in <= 1'b0;
    for (n = 0; n < 200 * TCK && rails_wake; n++) cyc(1);
    chk(32'(near(n, 64 * TCK)), 32'h1);
    wr(OFS_WAKE, 8'h18);
    irq_in <= 1'b1;
    cyc(3);
    chk(32'(irq_pin), 32'h1);
    chk(32'(rails_wake), 32'h0);
    wr(OFS_WAKE, 8'h20);
    cyc(3);
    chk(32'(irq_pin), 32'h1);
    chk(32'(rails_wake), 32'h0);
    irq_in <= 1'b0;
    $display("test wakeup done");
    for (c = 0; c < 4; c++) begin
      wr(OFS_LED, {2'b01, c[1:0], 4'h3});
      cyc(2);
      n = 0;
      for (i = 0; i < per[c]; i++) begin
        cyc(1);
        n += int'(!led_level);
      end
      chk(32'(near(n, lo[c])), 32'h1);
    end
    wr(OFS_CHG2, 8'h45);
    wr(OFS_LED, 8'h4b);
    cyc(3);
    chk(32'(led_level), 32'h0);
    wr(OFS_CHG2, 8'h55);
    cyc(3);
    chk(32'(led_level), 32'h1);
    $display("test indicator done");
    for (i = 0; i < 5; i++) begin
      // done is sticky while charging, so each case starts a fresh charge
      charging <= 1'b0;
      wr(OFS_CHG2, c34[i]);
      wr(OFS_CHG1, c33[i]);
      charging <= 1'b1;
      cur_ma <= 12'(cur[i]);
      cyc(4);
      chk(32'(cfg.chg_done), 32'(dn[i]));
      chk(32'(cfg.chg_out_on), 32'(!(dn[i] && !c34[i][5])));
    end
    charging <= 1'b0;
    $display("test charge_done done");
    // a short press must not carry over into the next one
    wr(OFS_KEY, 8'h5d);
    press <= 1'b1;
    cyc(500 * TCK);
    press <= 1'b0;
    cyc(4);
    press <= 1'b1;
    t_on = 0;
    t_irq = 0;
    t_off = 0;
    for (n = 1; n <= 6100 * TCK && t_off == 0; n++) begin
      cyc(1);
      if (key_on && t_on == 0) t_on = n;
      if (key_irq && t_irq == 0) t_irq = n;
      if (key_off) t_off = n;
    end
    chk(32'(near(t_on, 1000 * TCK)), 32'h1);
    chk(32'(near(t_irq, 1500 * TCK)), 32'h1);
    chk(32'(near(t_off, 6000 * TCK)), 32'h1);
    press <= 1'b0;
    t_on = 0;
    for (n = 0; n < 4; n++) begin
      cyc(1);
      if (key_rst) t_on = 1;
    end
    chk(32'(t_on), 32'h1);
    $display("test power_key done");
    end_sim();
  end
endmodule
